// ==== src/duart_pkg.sv ====
// Shared constants for the dual UART command/status pair.
// Assumes a single 200 MHz ref_clk in both ends.
package duart_pkg;
	// Register addresses; bit 3 selects channel B
	localparam logic [3:0] ADDR_MR_A     = 4'h0;
	localparam logic [3:0] ADDR_SR_A     = 4'h1;
	localparam logic [3:0] ADDR_CR_A     = 4'h2;
	localparam logic [3:0] ADDR_DATA_A   = 4'h3;
	localparam logic [3:0] ADDR_ISR      = 4'h5;
	localparam logic [3:0] ADDR_MR_B     = 4'h8;
	localparam logic [3:0] ADDR_SR_B     = 4'h9;
	localparam logic [3:0] ADDR_CR_B     = 4'hA;
	localparam logic [3:0] ADDR_DATA_B   = 4'hB;
	localparam logic [3:0] ADDR_CT_START = 4'hE;
	localparam logic [3:0] ADDR_CT_STOP  = 4'hF;
	localparam logic [2:0] REG_MR        = 3'h0;
	localparam logic [2:0] REG_SR        = 3'h1;
	localparam logic [2:0] REG_CR        = 3'h2;
	localparam logic [2:0] REG_DATA      = 3'h3;
	// Miscellaneous command codes, command word bits 7:4
	localparam logic [3:0] CMD_RST_MRPTR  = 4'h1;
	localparam logic [3:0] CMD_RST_RX     = 4'h2;
	localparam logic [3:0] CMD_RST_TX     = 4'h3;
	localparam logic [3:0] CMD_RST_ERR    = 4'h4;
	localparam logic [3:0] CMD_RST_BRKCHG = 4'h5;
	localparam logic [3:0] CMD_START_BRK  = 4'h6;
	localparam logic [3:0] CMD_STOP_BRK   = 4'h7;
	localparam logic [3:0] CMD_RTS_ON     = 4'h8;
	localparam logic [3:0] CMD_RTS_OFF    = 4'h9;
	localparam logic [3:0] CMD_TO_ON      = 4'hA;
	localparam logic [3:0] CMD_MRPTR_ZERO = 4'hB;
	localparam logic [3:0] CMD_TO_OFF     = 4'hC;
	localparam logic [3:0] CMD_UNUSED     = 4'hD;
	localparam logic [3:0] CMD_PD_ON      = 4'hE;
	localparam logic [3:0] CMD_PD_OFF     = 4'hF;
	// Command word bits 3:0
	localparam int CR_RX_EN  = 0;
	localparam int CR_RX_DIS = 1;
	localparam int CR_TX_EN  = 2;
	localparam int CR_TX_DIS = 3;
	// Interrupt status word bits, then mode register 1 error-mode bit and last pointer value
	localparam int ISR_BRKCHG_A = 2;
	localparam int ISR_CT_READY = 3;
	localparam int ISR_BRKCHG_B = 6;
	localparam int MR1_ERR_MODE = 5;
	localparam logic [1:0] MR_PTR_LAST = 2'h2;
	// Timing
	localparam int CLK_MHZ          = 200;
	localparam int BIT_NS           = 80;
	localparam int BIT_CYCLES       = (BIT_NS * CLK_MHZ + 999) / 1000;
	localparam logic [4:0] BIT_LAST  = 5'(BIT_CYCLES - 1);
	localparam logic [4:0] HALF_LAST = 5'(BIT_CYCLES / 2 - 1);
	localparam int OSC_START_NS     = 10000;
	localparam int OSC_START_CYCLES = (OSC_START_NS * CLK_MHZ + 999) / 1000;
	localparam logic [10:0] OSC_LAST = 11'(OSC_START_CYCLES - 1);
	localparam logic [15:0] CT_PRELOAD = 16'h0100;
	localparam logic [4:0] FIFO_FULL   = 5'h10;
endpackage

// ==== src/duart_bus_if.sv ====
// Host register port between the processor end and the dual UART.
// Both ends run on the same ref_clk; strobes are one-cycle pulses.
`timescale 1ns/1ps
interface duart_bus_if;
	logic       wr_en;  // Write strobe
	logic       rd_en;  // Read strobe
	logic [3:0] addr;   // Register address
	logic [7:0] wdata;  // Write data
	logic [7:0] rdata;  // Read data
	logic       rvalid; // Read answer, cycle after rd_en
	modport device (input wr_en, rd_en, addr, wdata, output rdata, rvalid);
	modport host (input rdata, rvalid, output wr_en, rd_en, addr, wdata);
endinterface

// ==== src/duart_device.sv ====
// Dual UART channel pair: command decode, receivers, status, timer.
// Assumes serial lines are asynchronous and the host keeps its side.
// How it works
// - Time-out mode restarts timer per received character
// - Time-out on: stop timer, block start/stop, clear ready
// - Pointer command selects mode register zero next
// - Time-out off keeps counter and pending flags
// - Host issues stop counter after leaving time-out
// - Power-down halts oscillator, suspends all logic
// - Registers hold their contents while powered down
// - Host sends only wake-up while powered down
// - Host disables receiver and transmitter in the power-down write
// - Wake-up restarts oscillator; host waits start-up
// - Power-down codes act only on channel A
// - Several non-conflicting commands per write
// - Channel B decodes commands like channel A, except power-down codes
// - Status bits: break, framing, parity, overrun, tx, rx
// - Upper status from oldest entry in character mode, lower live
// - Character mode drops flags; block mode accumulates
// - Break takes one entry, waits half bit marking
// - Change-in-break set at break start and end
// - Breaks starting mid-character are caught
// - Break bit cleared only by error or rx reset in block mode
// - Framing error when first stop bit is low
// - Reset error clears break, parity, overrun bits
`timescale 1ns/1ps
module duart_device (
	input  wire logic   ref_clk,          // 200 MHz clock
	input  wire logic   rstn,             // Async reset, active low
	duart_bus_if.device bus,              // Host register port
	input  wire logic   serial_in_line_a, // Channel A serial input
	input  wire logic   serial_in_line_b, // Channel B serial input
	output logic [1:0]  rts_n,            // Request-to-send, active low
	output logic [1:0]  tx_break,         // Break being sent
	output logic        ct_ready,         // Counter ready flag
	output logic        osc_enable,       // Oscillator commanded on
	output logic        osc_running       // Oscillator stable, logic live
);
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_BRK} rx_state_t;
	typedef struct packed {
		logic       brk;
		logic       fe;
		logic       pe;
		logic [7:0] data;
	} rx_entry_t;
	typedef struct packed {
		rx_entry_t [15:0] fifo;
		logic [4:0]       cnt;
		logic [3:0]       rd_ptr;
		logic [3:0]       wr_ptr;
		rx_state_t        rx_st;
		logic [4:0]       tmr;
		logic [2:0]       idx;
		logic [7:0]       shreg;
		logic             rx_en;
		logic             tx_en;
		logic             overrun;
		logic [2:0]       err_acc;
		logic             brk_chg;
		logic             timeout;
		logic [1:0]       mr_ptr;
		logic [2:0][7:0]  mr;
		logic             rts;
		logic             tx_brk;
	} chan_t;
	typedef struct packed {
		chan_t [1:0] ch;
		logic [15:0] ct;
		logic        ct_run;
		logic        ct_ready;
		logic        osc_on;
		logic        osc_stable;
		logic [10:0] osc_tmr;
		logic [7:0]  rdata;
		logic        rvalid;
		logic [1:0]  rx_s1;
		logic [1:0]  rx_s2;
	} state_t;

	state_t q;
	state_t d;

	always_comb begin
		chan_t     c;
		rx_entry_t ent;
		rx_entry_t head;
		logic      cr_wr;
		logic      line;
		logic      ld;
		logic      brk_evt;
		logic      pop;
		logic      any_to;
		logic      ct_tc;
		logic [3:0] cmd;
		logic [2:0] upper;
		logic [7:0] sr;
		logic [7:0] interrupt_status_word;
		c = '0;
		ent = '0;
		head = '0;
		cr_wr = 1'b0;
		line = 1'b1;
		ld = 1'b0;
		brk_evt = 1'b0;
		pop = 1'b0;
		ct_tc = 1'b0;
		cmd = bus.wdata[7:4];
		upper = 3'h0;
		sr = 8'h00;
		interrupt_status_word = 8'h00;
		any_to = q.ch[0].timeout | q.ch[1].timeout;
		d = q;
		d.rvalid = 1'b0;
		if (!q.osc_stable) begin
			// Clock stopped: everything else frozen
			if (q.osc_on) begin
				d.osc_tmr = q.osc_tmr + 11'h001;
				if (q.osc_tmr == duart_pkg::OSC_LAST)
					d.osc_stable = 1'b1;
			end else if (bus.wr_en && bus.addr == duart_pkg::ADDR_CR_A &&
			             cmd == duart_pkg::CMD_PD_OFF) begin
				d.osc_on = 1'b1;
				d.osc_tmr = 11'h000;
			end
		end else begin
			d.rx_s1 = {serial_in_line_b, serial_in_line_a};
			d.rx_s2 = q.rx_s1;
			if (q.ct_run) begin
				if (q.ct == 16'h0000) begin
					d.ct = duart_pkg::CT_PRELOAD;
					ct_tc = 1'b1;
				end else begin
					d.ct = q.ct - 16'h0001;
				end
			end
			if (bus.rd_en && !any_to && bus.addr == duart_pkg::ADDR_CT_START) begin
				d.ct = duart_pkg::CT_PRELOAD;
				d.ct_run = 1'b1;
			end
			if (bus.rd_en && !any_to && bus.addr == duart_pkg::ADDR_CT_STOP) begin
				d.ct_run = 1'b0;
				d.ct_ready = 1'b0;
			end
			interrupt_status_word[duart_pkg::ISR_CT_READY] = q.ct_ready;
			interrupt_status_word[duart_pkg::ISR_BRKCHG_A] = q.ch[0].brk_chg;
			interrupt_status_word[duart_pkg::ISR_BRKCHG_B] = q.ch[1].brk_chg;
			if (bus.rd_en) begin
				d.rvalid = 1'b1;
				d.rdata = (bus.addr == duart_pkg::ADDR_ISR) ? interrupt_status_word : 8'h00;
			end
			for (int i = 0; i < 2; i++) begin
				c = q.ch[i];
				line = q.rx_s2[i];
				ld = 1'b0;
				brk_evt = 1'b0;
				ent = '0;
				head = q.ch[i].fifo[q.ch[i].rd_ptr];
				cr_wr = bus.wr_en && bus.addr == {1'(i), duart_pkg::REG_CR};
				// Receiver
				c.tmr = q.ch[i].tmr + 5'h01;
				case (q.ch[i].rx_st)
					RX_IDLE: begin
						c.tmr = 5'h00;
						if (q.ch[i].rx_en && !line)
							c.rx_st = RX_START;
					end
					RX_START: begin
						if (q.ch[i].tmr == duart_pkg::HALF_LAST) begin
							c.tmr = 5'h00;
							c.idx = 3'h0;
							c.rx_st = line ? RX_IDLE : RX_DATA;
						end
					end
					RX_DATA: begin
						if (q.ch[i].tmr == duart_pkg::BIT_LAST) begin
							c.tmr = 5'h00;
							c.shreg = {line, q.ch[i].shreg[7:1]};
							c.idx = q.ch[i].idx + 3'h1;
							if (q.ch[i].idx == 3'h7)
								c.rx_st = RX_STOP;
						end
					end
					RX_STOP: begin
						if (q.ch[i].tmr == duart_pkg::BIT_LAST) begin
							c.tmr = 5'h00;
							ld = 1'b1;
							ent.data = q.ch[i].shreg;
							if (q.ch[i].shreg == 8'h00 && !line) begin
								ent.brk = 1'b1;
								brk_evt = 1'b1;
								c.rx_st = RX_BRK;
							end else begin
								ent.fe = !line;
								c.rx_st = RX_IDLE;
							end
						end
					end
					RX_BRK: begin
						// No loads until half a bit of marking
						if (!line) begin
							c.tmr = 5'h00;
						end else if (q.ch[i].tmr == duart_pkg::HALF_LAST) begin
							brk_evt = 1'b1;
							c.rx_st = RX_IDLE;
						end
					end
					default: c.rx_st = RX_IDLE;
				endcase
				if (!q.ch[i].rx_en) begin
					c.rx_st = RX_IDLE;
					ld = 1'b0;
				end
				// Receive FIFO with flags per entry
				pop = bus.rd_en && bus.addr == {1'(i), duart_pkg::REG_DATA} &&
				      q.ch[i].cnt != 5'h00;
				if (pop) begin
					c.rd_ptr = q.ch[i].rd_ptr + 4'h1;
					c.cnt = c.cnt - 5'h01;
				end
				if (ld && q.ch[i].cnt != duart_pkg::FIFO_FULL) begin
					c.fifo[q.ch[i].wr_ptr] = ent;
					c.wr_ptr = q.ch[i].wr_ptr + 4'h1;
					c.cnt = c.cnt + 5'h01;
					if (q.ch[i].timeout) begin
						d.ct = duart_pkg::CT_PRELOAD;
						d.ct_run = 1'b1;
					end
				end
				// Mode registers behind the pointer
				if ((bus.wr_en || bus.rd_en) && bus.addr == {1'(i), duart_pkg::REG_MR}) begin
					if (bus.wr_en)
						c.mr[q.ch[i].mr_ptr] = bus.wdata;
					if (q.ch[i].mr_ptr != duart_pkg::MR_PTR_LAST)
						c.mr_ptr = q.ch[i].mr_ptr + 2'h1;
				end
				// Commands; enable and disable bits combine with a code
				if (cr_wr) begin
					if (bus.wdata[duart_pkg::CR_RX_DIS])
						c.rx_en = 1'b0;
					if (bus.wdata[duart_pkg::CR_RX_EN])
						c.rx_en = 1'b1;
					if (bus.wdata[duart_pkg::CR_TX_DIS])
						c.tx_en = 1'b0;
					if (bus.wdata[duart_pkg::CR_TX_EN])
						c.tx_en = 1'b1;
					case (cmd)
						duart_pkg::CMD_RST_MRPTR: c.mr_ptr = 2'h1;
						duart_pkg::CMD_RST_RX: begin
							c.rx_en = 1'b0;
							c.rx_st = RX_IDLE;
							c.cnt = 5'h00;
							c.rd_ptr = 4'h0;
							c.wr_ptr = 4'h0;
							c.err_acc = 3'h0;
							c.overrun = 1'b0;
						end
						duart_pkg::CMD_RST_TX: begin
							c.tx_en = 1'b0;
							c.tx_brk = 1'b0;
						end
						duart_pkg::CMD_RST_ERR: begin
							c.overrun = 1'b0;
							c.err_acc = 3'h0;
							for (int j = 0; j < 16; j++) begin
								c.fifo[j].brk = 1'b0;
								c.fifo[j].fe = 1'b0;
								c.fifo[j].pe = 1'b0;
							end
						end
						duart_pkg::CMD_RST_BRKCHG: c.brk_chg = 1'b0;
						duart_pkg::CMD_START_BRK: c.tx_brk = c.tx_en;
						duart_pkg::CMD_STOP_BRK: c.tx_brk = 1'b0;
						duart_pkg::CMD_RTS_ON: c.rts = 1'b1;
						duart_pkg::CMD_RTS_OFF: c.rts = 1'b0;
						duart_pkg::CMD_TO_ON: begin
							c.timeout = 1'b1;
							d.ct_run = 1'b0;
							d.ct_ready = 1'b0;
						end
						duart_pkg::CMD_TO_OFF: c.timeout = 1'b0;
						duart_pkg::CMD_MRPTR_ZERO: c.mr_ptr = 2'h0;
						duart_pkg::CMD_PD_ON: begin
							if (i == 0) begin
								d.osc_on = 1'b0;
								d.osc_stable = 1'b0;
							end
						end
						default: c.mr_ptr = c.mr_ptr;
					endcase
				end
				// Hardware sets win over same-cycle clears
				if (brk_evt)
					c.brk_chg = 1'b1;
				if (ld && q.ch[i].cnt == duart_pkg::FIFO_FULL)
					c.overrun = 1'b1;
				if (ld)
					c.err_acc = c.err_acc | {ent.brk, ent.fe, ent.pe};
				// Status word
				if (q.ch[i].mr[1][duart_pkg::MR1_ERR_MODE])
					upper = q.ch[i].err_acc;
				else if (q.ch[i].cnt != 5'h00)
					upper = {head.brk, head.fe, head.pe};
				else
					upper = 3'h0;
				sr = {upper, q.ch[i].overrun, q.ch[i].tx_en, q.ch[i].tx_en,
				      q.ch[i].cnt == duart_pkg::FIFO_FULL, q.ch[i].cnt != 5'h00};
				if (bus.rd_en && bus.addr[3] == 1'(i)) begin
					case (bus.addr[2:0])
						duart_pkg::REG_MR: d.rdata = q.ch[i].mr[q.ch[i].mr_ptr];
						duart_pkg::REG_SR: d.rdata = sr;
						duart_pkg::REG_DATA: d.rdata = head.data;
						default: d.rdata = d.rdata;
					endcase
				end
				d.ch[i] = c;
			end
			if (ct_tc)
				d.ct_ready = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
			q.osc_on <= 1'b1;
			q.osc_stable <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign bus.rdata = q.rdata;
	assign bus.rvalid = q.rvalid;
	assign rts_n = ~{q.ch[1].rts, q.ch[0].rts};
	assign tx_break = {q.ch[1].tx_brk, q.ch[0].tx_brk};
	assign ct_ready = q.ct_ready;
	assign osc_enable = q.osc_on;
	assign osc_running = q.osc_stable;
endmodule // duart_device

// ==== src/duart_host.sv ====
// Processor end: turns user requests into register port cycles.
// Assumes the device answers every read one cycle after the strobe.
`timescale 1ns/1ps
module duart_host (
	input  wire logic  ref_clk,      // 200 MHz clock
	input  wire logic  rstn,         // Async reset, active low
	duart_bus_if.host  bus,          // Register port to device
	input  wire logic  req,          // Request, taken when req_ready
	input  wire logic  req_write,    // 1 write, 0 read
	input  wire logic  [3:0] req_addr, // Register address
	input  wire logic  [7:0] req_data, // Write data
	output logic       req_ready,    // Idle, request may be given
	output logic       done,         // Request finished, pulse
	output logic       refused,      // Request refused, pulse
	output logic [7:0] rd_result,    // Last read data
	output logic       powered_down  // Device held in power-down
);
	typedef enum logic [1:0] {H_IDLE, H_BUS, H_RD, H_WAKE} host_state_t;
	typedef struct packed {
		host_state_t st;
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [7:0]  wdata;
		logic        silent;
		logic        follow;
		logic        wake;
		logic        pd;
		logic [10:0] tmr;
		logic        done;
		logic        refused;
		logic [7:0]  result;
	} hstate_t;

	hstate_t q;
	hstate_t d;

	always_comb begin
		logic [3:0] cmd;
		logic       is_cr;
		logic       pd_off;
		logic       conflict;
		cmd = req_data[7:4];
		is_cr = req_write && (req_addr == duart_pkg::ADDR_CR_A ||
		                      req_addr == duart_pkg::ADDR_CR_B);
		pd_off = req_write && req_addr == duart_pkg::ADDR_CR_A && cmd == duart_pkg::CMD_PD_OFF;
		conflict = (req_data[duart_pkg::CR_RX_EN] & req_data[duart_pkg::CR_RX_DIS]) |
		           (req_data[duart_pkg::CR_TX_EN] & req_data[duart_pkg::CR_TX_DIS]) |
		           (cmd == duart_pkg::CMD_RST_RX & req_data[duart_pkg::CR_RX_EN]) |
		           (cmd == duart_pkg::CMD_RST_TX & req_data[duart_pkg::CR_TX_EN]);
		d = q;
		d.done = 1'b0;
		d.refused = 1'b0;
		case (q.st)
			H_IDLE: begin
				if (req) begin
					if ((q.pd && !pd_off) || (is_cr && conflict)) begin
						d.refused = 1'b1;
					end else begin
						d.addr = req_addr;
						d.wdata = req_data;
						d.wr = req_write;
						d.rd = !req_write;
						d.silent = 1'b0;
						d.wake = pd_off;
						d.follow = is_cr && cmd == duart_pkg::CMD_TO_OFF;
						d.st = H_BUS;
						if (req_write && req_addr == duart_pkg::ADDR_CR_A &&
						    cmd == duart_pkg::CMD_PD_ON) begin
							// Enables dropped, disables added in the same word
							d.wdata = {duart_pkg::CMD_PD_ON, 4'h0};
							d.wdata[duart_pkg::CR_RX_DIS] = 1'b1;
							d.wdata[duart_pkg::CR_TX_DIS] = 1'b1;
							d.pd = 1'b1;
						end
					end
				end
			end
			H_BUS: begin
				d.wr = 1'b0;
				d.rd = 1'b0;
				if (q.rd) begin
					d.st = H_RD;
				end else if (q.wake) begin
					d.tmr = 11'h000;
					d.st = H_WAKE;
				end else if (q.follow) begin
					d.follow = 1'b0;
					d.rd = 1'b1;
					d.addr = duart_pkg::ADDR_CT_STOP;
					d.silent = 1'b1;
				end else begin
					d.done = 1'b1;
					d.st = H_IDLE;
				end
			end
			H_RD: begin
				if (bus.rvalid) begin
					if (!q.silent)
						d.result = bus.rdata;
					d.done = 1'b1;
					d.st = H_IDLE;
				end
			end
			H_WAKE: begin
				d.tmr = q.tmr + 11'h001;
				if (q.tmr == duart_pkg::OSC_LAST) begin
					d.pd = 1'b0;
					d.done = 1'b1;
					d.st = H_IDLE;
				end
			end
			default: d.st = H_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			q <= '0;
		else
			q <= d;
	end

	assign bus.wr_en = q.wr;
	assign bus.rd_en = q.rd;
	assign bus.addr = q.addr;
	assign bus.wdata = q.wdata;
	assign req_ready = (q.st == H_IDLE);
	assign done = q.done;
	assign refused = q.refused;
	assign rd_result = q.result;
	assign powered_down = q.pd;
endmodule // duart_host

// ==== verification/duart_props.sv ====
// Register-port checks between the processor end and the dual UART.
// Assumes it sits beside the one port whose ends are both design modules.
`timescale 1ns/1ps
module duart_props (
	input wire logic       ref_clk, // 200 MHz clock
	input wire logic       rstn,    // Async reset, active low
	input wire logic       wr_en,   // Write strobe
	input wire logic       rd_en,   // Read strobe
	input wire logic [3:0] addr,    // Register address
	input wire logic [7:0] wdata,   // Write data
	input wire logic [7:0] rdata,   // Read data
	input wire logic       rvalid   // Read answer
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// A little short of the start-up span, so host pacing jitter never fires it
	localparam int WAKE_WAIT = duart_pkg::OSC_START_CYCLES - 8;
	logic        cr_w;
	logic        wake_w;
	logic        sr_rd;
	logic [11:0] wake_q;
	logic [11:0] wake_d;
	assign cr_w   = wr_en && addr[2:0] == duart_pkg::REG_CR;
	assign wake_w = cr_w && !addr[3] && wdata[7:4] == duart_pkg::CMD_PD_OFF;
	assign sr_rd  = rd_en && addr[2:0] == duart_pkg::REG_SR;
	always_comb begin
		wake_d = (wake_q != 12'h000) ? wake_q - 12'h001 : 12'h000;
		if (wake_w) wake_d = 12'(WAKE_WAIT);
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) wake_q <= 12'h000;
		else wake_q <= wake_d;
	end
	property p_rd_answer; rd_en |=> rvalid ##1 !rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_rv_cause; rvalid |-> $past(rd_en); endproperty
	a_rv_cause: assert property (p_rv_cause) else $error("answer without read");
	property p_rd_hold; !rvalid |-> $stable(rdata); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_tx_pair; sr_rd |=> rdata[3] == rdata[2]; endproperty
	a_tx_pair: assert property (p_tx_pair) else $error("tx status pair split");
	property p_full_rdy; sr_rd |=> (!rdata[1] || rdata[0]) && !rdata[5]; endproperty
	a_full_rdy: assert property (p_full_rdy) else $error("status bits inconsistent");
	property p_no_conflict;
		cr_w |-> !(wdata[0] && wdata[1]) && !(wdata[2] && wdata[3])
			&& !(wdata[7:4] == duart_pkg::CMD_RST_RX && wdata[0])
			&& !(wdata[7:4] == duart_pkg::CMD_RST_TX && wdata[2]);
	endproperty
	a_no_conflict: assert property (p_no_conflict) else $error("conflicting command");
	property p_pd_prep; cr_w && !addr[3] && wdata[7:4] == duart_pkg::CMD_PD_ON |-> wdata[1] && wdata[3];
	endproperty
	a_pd_prep: assert property (p_pd_prep) else $error("sleep with rx or tx on");
	property p_pd_quiet;
		cr_w && !addr[3] && wdata[7:4] == duart_pkg::CMD_PD_ON |=> !(rd_en || (wr_en && !wake_w)) [*8];
	endproperty
	a_pd_quiet: assert property (p_pd_quiet) else $error("access while asleep");
	property p_wake_wait; rd_en || (wr_en && !wake_w) |-> wake_q == 12'h000; endproperty
	a_wake_wait: assert property (p_wake_wait) else $error("access during start-up");
	property p_to_stop;
		cr_w && wdata[7:4] == duart_pkg::CMD_TO_OFF |-> ##[1:4] (rd_en && addr == duart_pkg::ADDR_CT_STOP);
	endproperty
	a_to_stop: assert property (p_to_stop) else $error("no stop after time-out off");
endmodule // duart_props

// ==== verification/test_uart_channel_command_status.sv ====
// Bench for host and device ends joined by one register port.
// Assumes nothing outside: serial lines and a rule-breaking raw port are driven here.
`timescale 1ns/1ps
module test_uart_channel_command_status;
	logic        ref_clk   = 1'b0;
	logic        rstn      = 1'b0;
	logic        req       = 1'b0;
	logic        req_write = 1'b0;
	logic [3:0]  req_addr  = 4'h0;
	logic [7:0]  req_data  = 8'h00;
	logic [1:0]  sin       = 2'b11;
	logic [31:0] seed      = 32'hD1BD0818;
	logic        req_ready, done, refused, powered_down, ct_ready, osc_enable, osc_running;
	logic        oen2, orun2, was_ref;
	logic [7:0]  rd_result;
	logic [1:0]  rts_n, tx_break, rts2_n;
	int          err_total   = 0;
	int          checks_done = 0;
	duart_bus_if bus ();
	duart_bus_if bus2 ();
	always #2.5 ref_clk = ~ref_clk;
	duart_host duart_host_inst (.ref_clk(ref_clk), .rstn(rstn), .bus(bus), .req(req),
		.req_write(req_write), .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
		.done(done), .refused(refused), .rd_result(rd_result), .powered_down(powered_down));
	duart_device duart_device_inst (.ref_clk(ref_clk), .rstn(rstn), .bus(bus),
		.serial_in_line_a(sin[0]), .serial_in_line_b(sin[1]), .rts_n(rts_n),
		.tx_break(tx_break), .ct_ready(ct_ready), .osc_enable(osc_enable),
		.osc_running(osc_running));
	// Raw port: lets the bench break the host's duties on purpose
	duart_device duart_device_raw_inst (.ref_clk(ref_clk), .rstn(rstn), .bus(bus2),
		.serial_in_line_a(1'b1), .serial_in_line_b(1'b1), .rts_n(rts2_n), .tx_break(),
		.ct_ready(), .osc_enable(oen2), .osc_running(orun2));
	duart_props duart_props_inst (.ref_clk(ref_clk), .rstn(rstn), .wr_en(bus.wr_en),
		.rd_en(bus.rd_en), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
		.rvalid(bus.rvalid));
	function automatic logic [7:0] sr(input logic brk, fe, ov, tx, full, rdy);
		return {brk, fe, 1'b0, ov, tx, tx, full, rdy};
	endfunction
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic summarize;
		if (err_total == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic op(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		#1;
		req = 1'b1;
		req_write = w;
		req_addr = a;
		req_data = d;
		@(posedge ref_clk);
		#1;
		req = 1'b0;
		while (!done && !refused && n < 2100) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		was_ref = refused;
		if (n >= 2100) chk(8'h00, 8'h01, "request hung");
		chk({7'h00, req_ready}, 8'h01, "host idle after answer");
	endtask
	task automatic command_port_first_channel(input logic [7:0] d);
		op(1'b1, duart_pkg::ADDR_CR_A, d);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
		op(1'b0, a, 8'h00);
		chk(rd_result, exp, what);
	endtask
	task automatic channel_a_line_status(input logic [7:0] exp, input string what);
		rd(duart_pkg::ADDR_SR_A, exp, what);
	endtask
	// Low stop on a non-zero char is cut short so the start it triggers fails its mid-bit check
	task automatic send(input int ch, input logic [7:0] b, input logic stp);
		logic [9:0] f;
		f = {stp, b, 1'b0};
		@(posedge ref_clk);
		#1;
		for (int i = 0; i < 10; i++) begin
			sin[ch] = f[i];
			repeat ((i == 9 && !stp) ? 12 : 16) @(posedge ref_clk);
			#1;
		end
		if (b != 8'h00) sin[ch] = 1'b1;
	endtask
	task automatic raw_wr(input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		bus2.wr_en = 1'b1;
		bus2.addr = duart_pkg::ADDR_CR_A;
		bus2.wdata = d;
		@(posedge ref_clk);
		#1;
		bus2.wr_en = 1'b0;
	endtask
	initial begin
		repeat (40000) @(posedge ref_clk);
		err_total++;
		summarize();
	end
	initial begin
		bus2.wr_en = 1'b0;
		bus2.rd_en = 1'b0;
		bus2.addr = 4'h0;
		bus2.wdata = 8'h00;
		repeat (5) @(posedge ref_clk);
		#1;
		rstn = 1'b1;
		channel_a_line_status(8'h00, "sr reset");
		command_port_first_channel(8'h05);
		channel_a_line_status(sr(0, 0, 0, 1, 0, 0), "sr enabled");
		command_port_first_channel(8'h03);
		chk({7'h00, was_ref}, 8'h01, "rx clash");
		command_port_first_channel(8'h34);
		chk({7'h00, was_ref}, 8'h01, "tx clash");
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			send(0, seed[7:0], 1'b1);
			channel_a_line_status(sr(0, 0, 0, 1, 0, 1), "sr char");
			rd(duart_pkg::ADDR_DATA_A, seed[7:0], "rx data");
		end
		send(0, 8'hA5, 1'b0);
		channel_a_line_status(sr(0, 1, 0, 1, 0, 1), "framing");
		rd(duart_pkg::ADDR_DATA_A, 8'hA5, "fe data");
		channel_a_line_status(sr(0, 0, 0, 1, 0, 0), "char mode drop");
		send(0, 8'h00, 1'b0);
		repeat (20) @(posedge ref_clk);
		rd(duart_pkg::ADDR_ISR, 8'h04, "break start");
		command_port_first_channel(8'h50);
		rd(duart_pkg::ADDR_ISR, 8'h00, "break chg clr");
		channel_a_line_status(sr(1, 0, 0, 1, 0, 1), "break entry");
		sin[0] = 1'b1;
		repeat (20) @(posedge ref_clk);
		rd(duart_pkg::ADDR_ISR, 8'h04, "break end");
		rd(duart_pkg::ADDR_DATA_A, 8'h00, "break data");
		channel_a_line_status(sr(0, 0, 0, 1, 0, 0), "one entry");
		command_port_first_channel(8'h50);
		for (int k = 0; k < 17; k++) begin
			seed = lfsr(seed);
			send(0, seed[7:0] | 8'h01, 1'b1);
		end
		channel_a_line_status(sr(0, 0, 1, 1, 1, 1), "overrun");
		command_port_first_channel(8'h40);
		channel_a_line_status(sr(0, 0, 0, 1, 1, 1), "err reset");
		command_port_first_channel(8'h20);
		channel_a_line_status(sr(0, 0, 0, 1, 0, 0), "rx reset");
		command_port_first_channel(8'h01);
		command_port_first_channel(8'hB0);
		op(1'b1, duart_pkg::ADDR_MR_A, 8'h5A);
		op(1'b1, duart_pkg::ADDR_MR_A, 8'h20);
		command_port_first_channel(8'hB0);
		rd(duart_pkg::ADDR_MR_A, 8'h5A, "ptr zero");
		command_port_first_channel(8'h10);
		rd(duart_pkg::ADDR_MR_A, 8'h20, "ptr one");
		send(0, 8'h3C, 1'b0);
		rd(duart_pkg::ADDR_DATA_A, 8'h3C, "blk data");
		channel_a_line_status(sr(0, 1, 0, 1, 0, 0), "blk accum");
		command_port_first_channel(8'hD0);
		channel_a_line_status(sr(0, 1, 0, 1, 0, 0), "unused code");
		command_port_first_channel(8'h40);
		channel_a_line_status(sr(0, 0, 0, 1, 0, 0), "blk cleared");
		op(1'b0, duart_pkg::ADDR_CT_START, 8'h00);
		repeat (300) @(posedge ref_clk);
		chk({7'h00, ct_ready}, 8'h01, "ct expired");
		command_port_first_channel(8'hA0);
		chk({7'h00, ct_ready}, 8'h00, "to on clears");
		op(1'b0, duart_pkg::ADDR_CT_START, 8'h00);
		repeat (300) @(posedge ref_clk);
		chk({7'h00, ct_ready}, 8'h00, "start blocked");
		send(0, 8'h11, 1'b1);
		repeat (200) @(posedge ref_clk);
		chk({7'h00, ct_ready}, 8'h00, "restart early");
		repeat (100) @(posedge ref_clk);
		chk({7'h00, ct_ready}, 8'h01, "restart fired");
		op(1'b0, duart_pkg::ADDR_CT_STOP, 8'h00);
		chk({7'h00, ct_ready}, 8'h01, "stop blocked");
		rd(duart_pkg::ADDR_DATA_A, 8'h11, "to data");
		command_port_first_channel(8'hC0);
		chk({7'h00, ct_ready}, 8'h00, "to off stop");
		op(1'b1, duart_pkg::ADDR_CR_B, 8'h85);
		chk({6'h00, rts_n}, 8'h01, "b rts on");
		op(1'b1, duart_pkg::ADDR_CR_B, 8'h60);
		chk({6'h00, tx_break}, 8'h02, "b break");
		op(1'b1, duart_pkg::ADDR_CR_B, 8'h70);
		op(1'b1, duart_pkg::ADDR_CR_B, 8'hE0);
		chk({6'h00, osc_running, powered_down}, 8'h02, "b no sleep");
		seed = lfsr(seed);
		send(1, seed[7:0], 1'b1);
		rd(duart_pkg::ADDR_SR_B, sr(0, 0, 0, 1, 0, 1), "b sr");
		rd(duart_pkg::ADDR_DATA_B, seed[7:0], "b data");
		op(1'b1, duart_pkg::ADDR_CR_B, 8'h90);
		command_port_first_channel(8'h80);
		chk({6'h00, rts_n, tx_break}, 8'h08, "a rts, b off");
		command_port_first_channel(8'hE0);
		chk({6'h00, osc_enable, powered_down}, 8'h01, "sleep");
		op(1'b0, duart_pkg::ADDR_SR_A, 8'h00);
		chk({7'h00, was_ref}, 8'h01, "asleep refused");
		command_port_first_channel(8'hF0);
		chk({6'h00, osc_running, powered_down}, 8'h02, "woken");
		chk({6'h00, rts_n}, 8'h02, "rts kept");
		command_port_first_channel(8'hB0);
		rd(duart_pkg::ADDR_MR_A, 8'h5A, "mr kept");
		channel_a_line_status(8'h00, "rx tx off");
		raw_wr(8'hE0);
		raw_wr(8'h80);
		chk({6'h00, rts2_n}, 8'h03, "asleep cmd");
		raw_wr(8'hF0);
		chk({7'h00, orun2}, 8'h00, "starting");
		repeat (2010) @(posedge ref_clk);
		chk({6'h00, oen2, orun2}, 8'h03, "raw woken");
		summarize();
	end
endmodule // test_uart_channel_command_status
